// ==== verilog/rtcv_consts.svh ====
// Constants of the counter and calendar value block: offsets, fields, resets, timing
`ifndef RTCV_CONSTS_SVH
`define RTCV_CONSTS_SVH

// Register byte offsets
`define RTCV_OFS_CTRL        8'h00
`define RTCV_OFS_STATUS      8'h08
`define RTCV_OFS_VALUE       8'h10

// Control register fields
`define RTCV_CTRL_MODE_LSB   0
`define RTCV_CTRL_MODE_MSB   1
`define RTCV_CTRL_HOUR12_BIT 2
`define RTCV_CTRL_ENABLE_BIT 3

// Status register fields
`define RTCV_STAT_LEAP_BIT   0
`define RTCV_STAT_MODE_LSB   4
`define RTCV_STAT_MODE_MSB   5

// Calendar value field positions
`define RTCV_YEAR_MSB        31
`define RTCV_YEAR_LSB        26
`define RTCV_MONTH_MSB       25
`define RTCV_MONTH_LSB       22
`define RTCV_DAY_MSB         21
`define RTCV_DAY_LSB         17
`define RTCV_HOUR_MSB        16
`define RTCV_HOUR_LSB        12
`define RTCV_MINUTE_MSB      11
`define RTCV_MINUTE_LSB      6
`define RTCV_SECOND_MSB      5
`define RTCV_SECOND_LSB      0

// Reset values
`define RTCV_CTRL_RESET      32'h0000_0000
`define RTCV_COUNT16_RESET   16'h0000
`define RTCV_COUNT32_RESET   32'h0000_0000
`define RTCV_CLOCK_RESET     32'h0000_0000

// Timing: one count step per tick period
`define RTCV_CLK_KHZ         25000
`define RTCV_TICK_PERIOD_MS  1000
`define RTCV_TICK_CYCLES     (`RTCV_TICK_PERIOD_MS * `RTCV_CLK_KHZ)

`endif

// ==== verilog/rtcv_pkg.sv ====
// Types shared by the counter and calendar value block
`default_nettype none
package rtcv_pkg;

	typedef enum logic [1:0] {
		RTCV_MODE_COUNT32  = 2'b00,
		RTCV_MODE_COUNT16  = 2'b01,
		RTCV_MODE_CALENDAR = 2'b10,
		RTCV_MODE_RSVD     = 2'b11
	} rtcv_mode_t;

	typedef struct packed {
		logic [5:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rtcv_cal_t;

	typedef struct packed {
		logic       enable;
		logic       hour12;
		rtcv_mode_t mode;
	} rtcv_ctrl_t;

endpackage
`default_nettype wire

// ==== verilog/rtcv_cal.sv ====
// Calendar clock: seconds to years with carry, leap test and 12/24 hour forms
`default_nettype none
`include "rtcv_consts.svh"
module rtcv_cal (
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic               tick,
	input  wire logic               hour12,
	input  wire logic               load,
	input  wire rtcv_pkg::rtcv_cal_t load_val,
	output var  rtcv_pkg::rtcv_cal_t cal_reg,
	output var  logic               leap_reg
);
	import rtcv_pkg::*;

	rtcv_cal_t  cal_next;
	logic [4:0] last_day;
	logic       leap;

	////////////////////////////////////////////////////////////////////////////
	assign leap = (cal_reg.year[1:0] == 2'b00); // [RULE_04]

	always_comb begin
		case (cal_reg.month)
			4'd2:                      last_day = leap ? 5'd29 : 5'd28; // [RULE_06]
			4'd4, 4'd6, 4'd9, 4'd11:   last_day = 5'd30; // [RULE_06]
			default:                   last_day = 5'd31; // [RULE_06]
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		cal_next = cal_reg;
		if (cal_reg.second >= 6'd59) begin // [RULE_09]
			cal_next.second = 6'd0; // [RULE_10]
			if (cal_reg.minute >= 6'd59) begin // [RULE_09]
				cal_next.minute = 6'd0; // [RULE_10]
				if (hour12) begin
					// 11 rolls to 12 and flips AM/PM; 12 rolls to 1 without a flip
					if (cal_reg.hour[3:0] == 4'd11) begin // [RULE_08]
						cal_next.hour = {~cal_reg.hour[4], 4'd12}; // [RULE_08]
					end else if (cal_reg.hour[3:0] >= 4'd12) begin
						cal_next.hour = {cal_reg.hour[4], 4'd1}; // [RULE_08]
					end else begin
						cal_next.hour = {cal_reg.hour[4], cal_reg.hour[3:0] + 4'd1};
					end
				end else if (cal_reg.hour >= 5'd23) begin // [RULE_07]
					cal_next.hour = 5'd0; // [RULE_10]
				end else begin
					cal_next.hour = cal_reg.hour + 5'd1;
				end
				// Day turns at midnight: 23 to 0, or 11 PM to 12 AM
				if ((!hour12 && cal_reg.hour >= 5'd23) ||
				    (hour12 && cal_reg.hour == {1'b1, 4'd11})) begin
					if (cal_reg.day >= last_day) begin // [RULE_06]
						cal_next.day = 5'd1; // [RULE_10]
						if (cal_reg.month >= 4'd12) begin // [RULE_05]
							cal_next.month = 4'd1; // [RULE_10]
							cal_next.year  = cal_reg.year + 6'd1; // [RULE_03]
						end else begin
							cal_next.month = cal_reg.month + 4'd1;
						end
					end else begin
						cal_next.day = cal_reg.day + 5'd1;
					end
				end
			end else begin
				cal_next.minute = cal_reg.minute + 6'd1;
			end
		end else begin
			cal_next.second = cal_reg.second + 6'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cal_reg <= rtcv_cal_t'(`RTCV_CLOCK_RESET);
		end else if (load) begin
			cal_reg <= load_val;
		end else if (tick) begin
			cal_reg <= cal_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			leap_reg <= 1'b0;
		end else begin
			leap_reg <= leap; // [RULE_04]
		end
	end

endmodule
`default_nettype wire

// ==== verilog/rtcv_top.sv ====
// Counter and calendar value block with APB register access
//
// Behaviour
// [RULE_01] 32-bit counter mode shows the full running count in value bits 31:0.
// [RULE_02] 16-bit counter mode keeps the count in bits 15:0, reset to zero.
// [RULE_03] Calendar year is a six-bit offset from a software reference in bits 31:26.
// [RULE_04] A year is leap exactly when the offset's two low bits are zero.
// [RULE_05] Month sits in bits 25:22, January 1 through December 12.
// [RULE_06] Day sits in bits 21:17, from 1 to the month's last day.
// [RULE_07] With 24-hour form the hour in bits 16:12 runs 0 to 23.
// [RULE_08] With 12-hour form hour bits 3:0 run 1 to 12, bit 4 marks PM.
// [RULE_09] Minute in bits 11:6 and second in bits 5:0, each 0 to 59.
// [RULE_10] Each calendar field carries into the next when it passes its maximum.
//
// The APB register port was left to the implementer.
`default_nettype none
`include "rtcv_consts.svh"
module rtcv_top #(
	parameter int TICK_CYCLES = `RTCV_TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);
	import rtcv_pkg::*;

	rtcv_ctrl_t  ctrl_reg;
	logic [31:0] count_reg;
	logic [24:0] div_reg;
	logic        tick_reg;
	rtcv_cal_t   cal_reg;
	logic        leap_reg;
	logic        access;
	logic        wr_ctrl;
	logic        wr_value;
	logic        mapped;
	logic [31:0] value_rd;
	logic [31:0] value_wr;
	logic [31:0] rd_next;
	rtcv_ctrl_t  ctrl_next;
	logic [31:0] count_next;
	logic [24:0] div_next;
	logic        tick_next;
	logic        cal_tick;
	logic        cal_load;

	////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge for APB4 strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, pready is high in every access cycle
	assign access   = psel && penable && pready;
	assign mapped   = (paddr == `RTCV_OFS_CTRL) || (paddr == `RTCV_OFS_STATUS) ||
	                  (paddr == `RTCV_OFS_VALUE);
	assign wr_ctrl  = access && pwrite && !pslverr && (paddr == `RTCV_OFS_CTRL);
	assign wr_value = access && pwrite && !pslverr && (paddr == `RTCV_OFS_VALUE);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// Status is read-only, so a write to it is flagged as an error too
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !mapped || (pwrite && paddr == `RTCV_OFS_STATUS);
		end else begin
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Value view depends on mode; reserved mode reads as zero
	always_comb begin
		case (ctrl_reg.mode)
			RTCV_MODE_COUNT32:  value_rd = count_reg; // [RULE_01]
			RTCV_MODE_COUNT16:  value_rd = {16'h0000, count_reg[15:0]}; // [RULE_02]
			RTCV_MODE_CALENDAR: value_rd = cal_reg; // [RULE_03]
			default:            value_rd = 32'h0000_0000;
		endcase
	end

	assign value_wr = merge(value_rd, pwdata, pstrb);

	always_comb begin
		rd_next = 32'h0000_0000;
		case (paddr)
			`RTCV_OFS_CTRL: begin
				rd_next[`RTCV_CTRL_MODE_MSB:`RTCV_CTRL_MODE_LSB] = ctrl_reg.mode;
				rd_next[`RTCV_CTRL_HOUR12_BIT]                  = ctrl_reg.hour12;
				rd_next[`RTCV_CTRL_ENABLE_BIT]                  = ctrl_reg.enable;
			end
			`RTCV_OFS_STATUS: begin
				rd_next[`RTCV_STAT_LEAP_BIT]                    = leap_reg; // [RULE_04]
				rd_next[`RTCV_STAT_MODE_MSB:`RTCV_STAT_MODE_LSB] = ctrl_reg.mode;
			end
			`RTCV_OFS_VALUE: begin
				rd_next = value_rd;
			end
			default: begin
				rd_next = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured in the setup cycle and held through the access cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl && pstrb[0]) begin
			ctrl_next.mode   = rtcv_mode_t'(pwdata[`RTCV_CTRL_MODE_MSB:`RTCV_CTRL_MODE_LSB]);
			ctrl_next.hour12 = pwdata[`RTCV_CTRL_HOUR12_BIT]; // [RULE_07] [RULE_08]
			ctrl_next.enable = pwdata[`RTCV_CTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg <= rtcv_ctrl_t'(`RTCV_CTRL_RESET);
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tick divider: one count step per tick period while enabled
	// Held at zero while disabled, so each enable starts a full tick period
	always_comb begin
		div_next  = div_reg + 25'h0000001;
		tick_next = 1'b0;
		if (!ctrl_reg.enable) begin
			div_next = 25'h0000000;
		end else if (div_reg >= 25'(TICK_CYCLES - 1)) begin
			div_next  = 25'h0000000;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_reg  <= 25'h0000000;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter shared by both counter modes; software write beats a tick
	always_comb begin
		count_next = count_reg;
		if (wr_value && ctrl_reg.mode == RTCV_MODE_COUNT32) begin
			count_next = value_wr; // [RULE_01]
		end else if (wr_value && ctrl_reg.mode == RTCV_MODE_COUNT16) begin
			count_next = {16'h0000, value_wr[15:0]}; // [RULE_02]
		end else if (tick_reg && ctrl_reg.mode == RTCV_MODE_COUNT32) begin
			count_next = count_reg + 32'h0000_0001; // [RULE_01]
		end else if (tick_reg && ctrl_reg.mode == RTCV_MODE_COUNT16) begin
			// Upper half is kept clear so a mode change shows no stale bits
			count_next = {16'h0000, count_reg[15:0] + 16'h0001}; // [RULE_02]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_reg <= `RTCV_COUNT32_RESET;
		end else begin
			count_reg <= count_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Calendar runs only in calendar mode
	assign cal_tick = tick_reg && ctrl_reg.mode == RTCV_MODE_CALENDAR;
	assign cal_load = wr_value && ctrl_reg.mode == RTCV_MODE_CALENDAR;

	rtcv_cal u_cal (
		.clock    (clock),
		.rst_n    (rst_n),
		.tick     (cal_tick),
		.hour12   (ctrl_reg.hour12),
		.load     (cal_load),
		.load_val (rtcv_cal_t'(value_wr)),
		.cal_reg  (cal_reg),
		.leap_reg (leap_reg)
	);

endmodule
`default_nettype wire

// ==== tb/rtcv_top_props.sv ====
// Port-level checks of the value block register bus
`default_nettype none
`include "rtcv_consts.svh"
module rtcv_top_props #(
	parameter int TICK_CYCLES = 16
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic       setup;
	logic       bad;
	logic       rd_val;
	logic       st_wr;
	logic [1:0] mode_q;
	assign setup = psel && !penable;
	assign bad = !(paddr inside {`RTCV_OFS_CTRL, `RTCV_OFS_STATUS, `RTCV_OFS_VALUE});
	assign rd_val = setup && !pwrite && paddr == `RTCV_OFS_VALUE;
	assign st_wr = setup && pwrite && paddr == `RTCV_OFS_STATUS;
	// Shadow of the mode field, so value reads can be judged by mode
	always_ff @(posedge clock) begin
		if (!rst_n)
			mode_q <= 2'h0;
		else if (psel && penable && pready && pwrite && !pslverr && paddr == `RTCV_OFS_CTRL && pstrb[0])
			mode_q <= pwdata[1:0];
	end
	////////////////////////////////////////
	a_ready_after_setup: assert property (setup |=> pready) else $error("no pready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_only_setup: assert property (!setup |=> !pready) else $error("pready without setup");
	a_err_unmapped: assert property (setup && bad |=> pslverr) else $error("unmapped not refused");
	a_err_status_wr: assert property (st_wr |=> pslverr) else $error("status write not refused");
	a_ok_mapped: assert property (setup && !bad && !st_wr |=> !pslverr) else $error("mapped access refused");
	a_err_read_zero: assert property (setup && !pwrite && bad |=> prdata == 32'h0) else $error("refused read not 0");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_prdata_hold: assert property (!(setup && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
	a_upper_zero16: assert property (
		rd_val && mode_q == 2'h1 |=> prdata[31:16] == 16'h0) else $error("16-bit view upper not 0");
	c_write: cover property (setup && pwrite);
	c_refuse: cover property (pslverr);
	c_cal_read: cover property (rd_val && mode_q == 2'h2);
endmodule
bind rtcv_top rtcv_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));
`default_nettype wire

// ==== tb/rtc_counter_calendar_value_test.sv ====
// Self-checking bench of the counter and calendar value block
`default_nettype none
`include "rtcv_consts.svh"
module rtc_counter_calendar_value_test import rtcv_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// Short tick; the run window sits between the first and second tick
	localparam int TC = 16;
	logic        clock;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic [31:0] r;
	logic        er;
	logic [5:0]  y6;
	int          fails;
	int          n_tests;
	int          cyc;
	int          tn;
	rtcv_top #(.TICK_CYCLES(TC)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	always #20 clock = ~clock;
	////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request stands until pready is seen high at a rising edge; answer is taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	function automatic logic [31:0] mk(input logic [5:0] y, input logic [3:0] mo, input logic [4:0] d,
		input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
		return {y, mo, d, h, mi, s};
	endfunction
	function automatic logic [31:0] nxt(input logic [31:0] v, input logic h12);
		rtcv_cal_t  c;
		logic       dc;
		logic [4:0] last;
		c = v;
		dc = 1'b0;
		last = (c.month == 4'd2) ? (c.year[1:0] == 2'b00 ? 5'd29 : 5'd28) :
			(c.month inside {4'd4, 4'd6, 4'd9, 4'd11}) ? 5'd30 : 5'd31;
		if (c.second < 6'd59) c.second++;
		else begin
			c.second = 6'd0;
			if (c.minute < 6'd59) c.minute++;
			else begin
				c.minute = 6'd0;
				if (!h12) begin
					dc = (c.hour == 5'd23);
					c.hour = dc ? 5'd0 : c.hour + 5'd1;
				end else if (c.hour[3:0] == 4'd12) c.hour[3:0] = 4'd1;
				else begin
					c.hour[3:0]++;
					if (c.hour[3:0] == 4'd12) c.hour[4] = ~c.hour[4];
					dc = (c.hour[3:0] == 4'd12) && !c.hour[4];
				end
			end
		end
		if (dc && c.day < last) c.day++;
		else if (dc) begin
			c.day = 5'd1;
			if (c.month < 4'd12) c.month++;
			else begin
				c.month = 4'd1;
				c.year++;
			end
		end
		return c;
	endfunction
	task automatic step(input rtcv_mode_t m, input logic h12, input logic [31:0] v, input logic [31:0] exp);
		apb(1'b1, `RTCV_OFS_CTRL, {28'h0, 1'b0, h12, m});
		apb(1'b1, `RTCV_OFS_VALUE, v);
		apb(1'b1, `RTCV_OFS_CTRL, {28'h0, 1'b1, h12, m});
		repeat (TC + TC / 4) @(posedge clock);
		apb(1'b1, `RTCV_OFS_CTRL, {28'h0, 1'b0, h12, m});
		apb(1'b0, `RTCV_OFS_VALUE, 32'h0);
		chk(rd, exp);
		if (m == RTCV_MODE_CALENDAR) begin
			apb(1'b0, `RTCV_OFS_STATUS, 32'h0);
			chk({31'h0, rd[0]}, {31'h0, exp[27:26] == 2'b00});
		end
		tn++;
		$display("test %0d done", tn);
	endtask
	task automatic cal(input logic h12, input logic [31:0] v);
		step(RTCV_MODE_CALENDAR, h12, v, nxt(v, h12));
	endtask
	////////////////////////////////////////
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		void'($urandom(32'hef0e));
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, `RTCV_OFS_CTRL, 32'h0);
		chk(rd, `RTCV_CTRL_RESET);
		apb(1'b0, `RTCV_OFS_VALUE, 32'h0);
		chk(rd, `RTCV_COUNT32_RESET);
		apb(1'b0, 8'h04, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, `RTCV_OFS_STATUS, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		r = $urandom;
		step(RTCV_MODE_COUNT32, 1'b0, r, r + 32'h1);
		step(RTCV_MODE_COUNT32, 1'b0, 32'hffff_ffff, 32'h0);
		step(RTCV_MODE_COUNT16, 1'b0, 32'hffff_ffff, 32'h0);
		r = $urandom;
		step(RTCV_MODE_COUNT16, 1'b0, r, {16'h0, r[15:0] + 16'h1});
		y6 = 6'($urandom);
		cal(1'b0, mk(y6 & 6'h3c, 4'd2, 5'd28, 5'd23, 6'd59, 6'd59));
		cal(1'b0, mk(y6 | 6'h01, 4'd2, 5'd28, 5'd23, 6'd59, 6'd59));
		cal(1'b0, mk(6'h3f, 4'd12, 5'd31, 5'd23, 6'd59, 6'd59));
		cal(1'b0, mk(y6, 4'd4, 5'd30, 5'd23, 6'd59, 6'd59));
		cal(1'b0, mk(y6, 4'd7, 5'd31, 5'd23, 6'd59, 6'd59));
		cal(1'b1, mk(y6, 4'd1, 5'd5, 5'h0b, 6'd59, 6'd59));
		cal(1'b1, mk(y6, 4'd1, 5'd5, 5'h1b, 6'd59, 6'd59));
		cal(1'b1, mk(y6, 4'd1, 5'd5, 5'h0c, 6'd59, 6'd59));
		for (int i = 0; i < 12; i++) begin
			cal(i[0], mk(6'($urandom), 4'($urandom_range(12, 1)), 5'($urandom_range(28, 1)),
				i[0] ? {1'($urandom), 4'($urandom_range(12, 1))} : 5'($urandom_range(23, 0)),
				6'($urandom_range(59, 57)), 6'($urandom_range(59, 57))));
		end
		final_report;
	end
endmodule
`default_nettype wire
